// File: src/ier_pkg.sv
package ier_pkg;

   // Register byte addresses (full system address, all 32 bits decoded).
   localparam logic [31:0] SEL_UPPER_ADDR = 32'h019C0000;
   localparam logic [31:0] SEL_LOWER_ADDR = 32'h019C0004;
   localparam logic [31:0] EVT_LATCH_LOW_ADDR = 32'h019C0010;
   localparam logic [31:0] EVT_LATCH_HIGH_ADDR = 32'h019C0014;
   localparam logic [31:0] EVT_ALLOW_LOW_ADDR = 32'h019C0018;
   localparam logic [31:0] EVT_ALLOW_HIGH_ADDR = 32'h019C001C;
   localparam logic [31:0] EVT_PEND_ADDR = 32'h019C0020;

   // Selector field geometry.
   localparam int SEL_W = 5;
   localparam int FIELD_LSB0 = 0;
   localparam int FIELD_LSB1 = 5;
   localparam int FIELD_LSB2 = 10;
   localparam int FIELD_LSB3 = 16;
   localparam int FIELD_LSB4 = 21;
   localparam int FIELD_LSB5 = 26;
   localparam logic [31:0] SEL_WMASK = 32'h7FFF7FFF;

   // Reset values of the two selector registers.
   localparam logic [31:0] SEL_LOWER_RST =
      {1'b0, 5'h09, 5'h08, 5'h07, 1'b0, 5'h06, 5'h05, 5'h04};
   localparam logic [31:0] SEL_UPPER_RST =
      {1'b0, 5'h02, 5'h01, 5'h00, 1'b0, 5'h0B, 5'h0A, 5'h03};

   // Selector codes.
   localparam logic [4:0] SRC_HOST = 5'h00;
   localparam logic [4:0] SRC_TIMER0 = 5'h01;
   localparam logic [4:0] SRC_TIMER1 = 5'h02;
   localparam logic [4:0] SRC_REFRESH = 5'h03;
   localparam logic [4:0] SRC_PIN4 = 5'h04;
   localparam logic [4:0] SRC_PIN5 = 5'h05;
   localparam logic [4:0] SRC_PIN6 = 5'h06;
   localparam logic [4:0] SRC_PIN7 = 5'h07;
   localparam logic [4:0] SRC_XFER_DONE = 5'h08;
   localparam logic [4:0] SRC_EMU_XFER = 5'h09;
   localparam logic [4:0] SRC_EMU_RX = 5'h0A;
   localparam logic [4:0] SRC_EMU_TX = 5'h0B;
   localparam logic [4:0] SRC_SER0_TX = 5'h0C;
   localparam logic [4:0] SRC_SER0_RX = 5'h0D;
   localparam logic [4:0] SRC_SER1_TX = 5'h0E;
   localparam logic [4:0] SRC_SER1_RX = 5'h0F;
   localparam logic [4:0] SRC_PIN0 = 5'h10;
   localparam logic [4:0] SRC_TIMER2 = 5'h13;

   // Channel numbers with fixed events.
   localparam int CH_TIMER2 = 19;
   localparam int CH_PIN8 = 48;
   localparam int NUM_CH = 64;
   localparam int NUM_IRQ = 16;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: src/ier_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser with a rising-edge pulse taken from the second stage.
module ier_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Asynchronous level in, synchronous level and edge out.
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] level_out,
   output logic [W-1:0] rise_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } ier_sync_s;

   ier_sync_s st_q;
   ier_sync_s st_d;

   // Shift the input through; the second and third stages feed the outputs.
   always_comb begin
      st_d.s1 = async_in;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
   end

   // Register the state.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign level_out = st_q.s2;
   assign rise_out = st_q.s2 & ~st_q.s3;

endmodule

`default_nettype wire

// File: src/ier_router.sv
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Function
// (RULE1) Sixteen core interrupt lines, line 0 highest priority, 15 lowest.
// (RULE2) Lines 0-3 fixed: reset, non-maskable, two reserved held low.
// (RULE3) Lines 4-15 each pick a source through a writable 5-bit selector.
// (RULE4) Upper selector at 0x019C0000, lower selector at 0x019C0004.
// (RULE5) Lower selector fields drive lines 4 to 9.
// (RULE6) Upper selector fields drive lines 10 to 15.
// (RULE7) Selectors reset to the documented default source codes.
// (RULE8) Codes 0-11 select host, timers, refresh, pins, done, emulation.
// (RULE9) Codes 12-16 and 19 select serial ports, pin 0, timer 2.
// (RULE10) Software never writes reserved selector codes.
// (RULE11) Transfer-done interrupt fires for completion on any channel 0-63.
// (RULE12) Sixty-four channels, each triggered only while its allow bit is set.
// (RULE13) Channels 0-15 carry host, timers, refresh, pins, serial events.
// (RULE14) Channel 19 timer 2, 48-55 pins 8-15, others have none.
// (RULE15) Channel events latch even while their allow bit is clear.
// (RULE16) Event priority comes from channel parameters, not this block.
// (RULE17) Every channel also triggers on completion or alternate completion.
// (RULE18) Selector writes take effect next cycle; bits 15 and 31 read zero.
module ier_router (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels.
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels.
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Fixed core sources, level from pins.
   input wire logic reset_req,
   input wire logic nmi_req,
   // Peripheral event pulses or levels, asynchronous to aclk.
   input wire logic host_irq,
   input wire logic timer0_irq,
   input wire logic timer1_irq,
   input wire logic timer2_irq,
   input wire logic refresh_timer_irq,
   input wire logic [15:0] pin_event,
   input wire logic serial0_tx_event,
   input wire logic serial0_rx_event,
   input wire logic serial1_tx_event,
   input wire logic serial1_rx_event,
   input wire logic emulation_transfer_irq,
   input wire logic emulation_rx_irq,
   input wire logic emulation_tx_irq,
   // Completion events from the transfer controller, same clock.
   input wire logic [63:0] xfer_complete,
   input wire logic [63:0] xfer_alt_complete,
   // Channel take-over: clears the pending bit of serviced channels.
   input wire logic [63:0] chan_service,
   // Core interrupt lines and transfer controller triggers.
   output logic [15:0] core_irq,
   output logic [63:0] chan_trigger
);

   typedef struct packed {
      logic [31:0] sel_upper;
      logic [31:0] sel_lower;
      logic [31:0] latch_low;
      logic [31:0] latch_high;
      logic [31:0] allow_low;
      logic [31:0] allow_high;
      logic [15:0] irq;
      logic [63:0] trig;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } ier_router_s;

   ier_router_s st_q;
   ier_router_s st_d;

   localparam int NSRC = 15;
   logic [NSRC-1:0] src_raw;
   logic [NSRC-1:0] src_lvl;
   logic [NSRC-1:0] src_rise;
   logic [15:0] pin_rise;
   logic [1:0] fixed_lvl;
   logic [31:0] src_vec;
   logic [63:0] chan_evt;
   logic xfer_done_any;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers for all asynchronous sources.
   assign src_raw = {emulation_tx_irq, emulation_rx_irq,
                     emulation_transfer_irq, serial1_rx_event,
                     serial1_tx_event, serial0_rx_event, serial0_tx_event,
                     refresh_timer_irq, timer2_irq, timer1_irq, timer0_irq,
                     host_irq, 1'b0, nmi_req, reset_req};

   ier_sync #(.W(NSRC)) u_src_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(src_raw),
      .level_out(src_lvl),
      .rise_out(src_rise)
   );

   ier_sync #(.W(16)) u_pin_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(pin_event),
      .level_out(),
      .rise_out(pin_rise)
   );

   assign fixed_lvl = src_lvl[1:0];

   ////////////////////////////////////////////////////////////////////////////
   // Source vector indexed by selector code; reserved codes give zero.
   // (RULE11) any channel done
   assign xfer_done_any = |xfer_complete;

   always_comb begin
      src_vec = '0;
      // (RULE8) code map
      src_vec[ier_pkg::SRC_HOST] = src_rise[3];
      src_vec[ier_pkg::SRC_TIMER0] = src_rise[4];
      src_vec[ier_pkg::SRC_TIMER1] = src_rise[5];
      src_vec[ier_pkg::SRC_REFRESH] = src_rise[7];
      src_vec[ier_pkg::SRC_PIN4] = pin_rise[4];
      src_vec[ier_pkg::SRC_PIN5] = pin_rise[5];
      src_vec[ier_pkg::SRC_PIN6] = pin_rise[6];
      src_vec[ier_pkg::SRC_PIN7] = pin_rise[7];
      src_vec[ier_pkg::SRC_XFER_DONE] = xfer_done_any;
      src_vec[ier_pkg::SRC_EMU_XFER] = src_rise[12];
      src_vec[ier_pkg::SRC_EMU_RX] = src_rise[13];
      src_vec[ier_pkg::SRC_EMU_TX] = src_rise[14];
      // (RULE9) extra codes
      src_vec[ier_pkg::SRC_SER0_TX] = src_rise[8];
      src_vec[ier_pkg::SRC_SER0_RX] = src_rise[9];
      src_vec[ier_pkg::SRC_SER1_TX] = src_rise[10];
      src_vec[ier_pkg::SRC_SER1_RX] = src_rise[11];
      src_vec[ier_pkg::SRC_PIN0] = pin_rise[0];
      src_vec[ier_pkg::SRC_TIMER2] = src_rise[6];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fixed channel event map; unlisted channels stay zero.
   always_comb begin
      chan_evt = '0;
      // (RULE13) channels 0 to 15
      chan_evt[0] = src_rise[3];
      chan_evt[1] = src_rise[4];
      chan_evt[2] = src_rise[5];
      chan_evt[3] = src_rise[7];
      chan_evt[7:4] = pin_rise[7:4];
      chan_evt[11:8] = pin_rise[3:0];
      chan_evt[15:12] = src_rise[11:8];
      // (RULE14) timer 2 and pins 8-15
      chan_evt[ier_pkg::CH_TIMER2] = src_rise[6];
      chan_evt[ier_pkg::CH_PIN8 +: 8] = pin_rise[15:8];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic: routing, event latching and the register slave.
   always_comb begin
      logic [4:0] f;
      logic [63:0] latch;
      logic [63:0] allow;
      logic [63:0] chained;
      logic [31:0] wmask;
      logic [31:0] rd;
      logic wr_ok;
      logic rd_ok;
      f = '0;
      wmask = '0;
      rd = '0;
      wr_ok = 1'b0;
      rd_ok = 1'b0;
      st_d = st_q;
      latch = {st_q.latch_high, st_q.latch_low};
      allow = {st_q.allow_high, st_q.allow_low};

      // (RULE2) fixed lines 0-3
      st_d.irq[0] = fixed_lvl[0];
      st_d.irq[1] = fixed_lvl[1];
      st_d.irq[3:2] = 2'b00;
      // (RULE3) lines 4-15 selected
      for (int i = 0; i < 12; i++) begin
         // (RULE5) lower fields
         // (RULE6) upper fields
         case (i % 6)
            0: f = (i < 6) ? st_q.sel_lower[ier_pkg::FIELD_LSB0 +: 5]
                           : st_q.sel_upper[ier_pkg::FIELD_LSB0 +: 5];
            1: f = (i < 6) ? st_q.sel_lower[ier_pkg::FIELD_LSB1 +: 5]
                           : st_q.sel_upper[ier_pkg::FIELD_LSB1 +: 5];
            2: f = (i < 6) ? st_q.sel_lower[ier_pkg::FIELD_LSB2 +: 5]
                           : st_q.sel_upper[ier_pkg::FIELD_LSB2 +: 5];
            3: f = (i < 6) ? st_q.sel_lower[ier_pkg::FIELD_LSB3 +: 5]
                           : st_q.sel_upper[ier_pkg::FIELD_LSB3 +: 5];
            4: f = (i < 6) ? st_q.sel_lower[ier_pkg::FIELD_LSB4 +: 5]
                           : st_q.sel_upper[ier_pkg::FIELD_LSB4 +: 5];
            default: f = (i < 6) ? st_q.sel_lower[ier_pkg::FIELD_LSB5 +: 5]
                                 : st_q.sel_upper[ier_pkg::FIELD_LSB5 +: 5];
         endcase
         st_d.irq[i + 4] = src_vec[f];
      end

      // (RULE17) completion chaining
      chained = xfer_complete | xfer_alt_complete;
      // (RULE15) latch regardless of allow
      latch = (latch & ~chan_service) | chan_evt | chained;
      // (RULE16) flat, unprioritised triggers
      // (RULE12) trigger only allowed
      st_d.trig = latch & allow;

      // Write path: take address and data together, then answer.
      if (st_q.bvalid) begin
         if (s_axi_bready) begin
            st_d.bvalid = 1'b0;
         end
         st_d.awready = 1'b0;
         st_d.wready = 1'b0;
      end else if (s_axi_awvalid && s_axi_wvalid) begin
         st_d.awready = 1'b1;
         st_d.wready = 1'b1;
      end else begin
         st_d.awready = 1'b0;
         st_d.wready = 1'b0;
      end
      if (st_q.awready && st_q.wready) begin
         st_d.awready = 1'b0;
         st_d.wready = 1'b0;
         st_d.bvalid = 1'b1;
         wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
         wr_ok = 1'b1;
         // (RULE4) register decode
         // (RULE18) reserved bits stay zero
         if (s_axi_awaddr == ier_pkg::SEL_UPPER_ADDR) begin
            st_d.sel_upper = (st_q.sel_upper & ~wmask) |
                             (s_axi_wdata & wmask & ier_pkg::SEL_WMASK);
         end else if (s_axi_awaddr == ier_pkg::SEL_LOWER_ADDR) begin
            st_d.sel_lower = (st_q.sel_lower & ~wmask) |
                             (s_axi_wdata & wmask & ier_pkg::SEL_WMASK);
         end else if (s_axi_awaddr == ier_pkg::EVT_LATCH_LOW_ADDR) begin
            latch[31:0] = latch[31:0] & ~(s_axi_wdata & wmask);
         end else if (s_axi_awaddr == ier_pkg::EVT_LATCH_HIGH_ADDR) begin
            latch[63:32] = latch[63:32] & ~(s_axi_wdata & wmask);
         end else if (s_axi_awaddr == ier_pkg::EVT_ALLOW_LOW_ADDR) begin
            st_d.allow_low = (st_q.allow_low & ~wmask) | (s_axi_wdata & wmask);
         end else if (s_axi_awaddr == ier_pkg::EVT_ALLOW_HIGH_ADDR) begin
            st_d.allow_high = (st_q.allow_high & ~wmask) |
                              (s_axi_wdata & wmask);
         end else begin
            wr_ok = 1'b0;
         end
         st_d.bresp = wr_ok ? ier_pkg::RESP_OKAY : ier_pkg::RESP_SLVERR;
      end
      // New events win over a software clear in the same cycle.
      latch = latch | chan_evt | chained;
      st_d.latch_low = latch[31:0];
      st_d.latch_high = latch[63:32];

      // Read path: one-cycle arready, data the cycle after.
      st_d.arready = 1'b0;
      if (st_q.rvalid) begin
         if (s_axi_rready) begin
            st_d.rvalid = 1'b0;
         end
      end else if (st_q.arready) begin
         rd_ok = 1'b1;
         if (s_axi_araddr == ier_pkg::SEL_UPPER_ADDR) begin
            rd = st_q.sel_upper;
         end else if (s_axi_araddr == ier_pkg::SEL_LOWER_ADDR) begin
            rd = st_q.sel_lower;
         end else if (s_axi_araddr == ier_pkg::EVT_LATCH_LOW_ADDR) begin
            rd = st_q.latch_low;
         end else if (s_axi_araddr == ier_pkg::EVT_LATCH_HIGH_ADDR) begin
            rd = st_q.latch_high;
         end else if (s_axi_araddr == ier_pkg::EVT_ALLOW_LOW_ADDR) begin
            rd = st_q.allow_low;
         end else if (s_axi_araddr == ier_pkg::EVT_ALLOW_HIGH_ADDR) begin
            rd = st_q.allow_high;
         end else if (s_axi_araddr == ier_pkg::EVT_PEND_ADDR) begin
            rd = {16'h0000, st_q.irq};
         end else begin
            rd_ok = 1'b0;
         end
         st_d.rdata = rd;
         st_d.rresp = rd_ok ? ier_pkg::RESP_OKAY : ier_pkg::RESP_SLVERR;
         st_d.rvalid = 1'b1;
      end else if (s_axi_arvalid) begin
         st_d.arready = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register with synchronous reset.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
         // (RULE7) default selectors
         st_q.sel_upper <= ier_pkg::SEL_UPPER_RST;
         st_q.sel_lower <= ier_pkg::SEL_LOWER_RST;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register.
   // (RULE1) line 0 highest priority
   assign core_irq = st_q.irq;
   assign chan_trigger = st_q.trig;
   assign s_axi_awready = st_q.awready;
   assign s_axi_wready = st_q.wready;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rresp = st_q.rresp;
   assign s_axi_rdata = st_q.rdata;

endmodule

`default_nettype wire

// File: tb/ier_core_model.sv
`timescale 1ns/10ps
`default_nettype none

// Far-side stand-in: a transfer controller that takes over new triggers.
module ier_core_model (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Router outputs seen by the core and the controller.
   input wire logic [15:0] core_irq,
   input wire logic [63:0] chan_trigger,
   // Take-over pulses and their running count.
   output logic [63:0] chan_service,
   output var int n_svc
);
   logic [63:0] trig_q;

   // priority not modelled here.
   // Service each channel once, on the rise of its trigger only.
   always @(posedge aclk) begin
      if (!aresetn) begin
         trig_q <= '0;
         chan_service <= '0;
         n_svc <= 0;
      end else begin
         trig_q <= chan_trigger;
         chan_service <= chan_trigger & ~trig_q;
         n_svc <= n_svc + $countones(chan_trigger & ~trig_q);
      end
   end
endmodule

`default_nettype wire

// File: tb/ier_router_chk.sv
`timescale 1ns/10ps
`default_nettype none

// Watches the router's bus handshakes and its fixed core lines.
module ier_router_chk (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Fixed sources and routed outputs.
   input wire logic reset_req,
   input wire logic nmi_req,
   input wire logic [15:0] core_irq,
   input wire logic [63:0] chan_trigger
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_spare_low: assert property (core_irq[3:2] == 2'h0)
      else $error("Reserved core lines high.");
   a_nmi_on: assert property (nmi_req [*5] |-> core_irq[1])
      else $error("Held nmi request not shown.");
   a_nmi_off: assert property (!nmi_req [*5] |-> !core_irq[1])
      else $error("Nmi line high without request.");
   a_reset_on: assert property (reset_req [*5] |-> core_irq[0])
      else $error("Held reset request not shown.");
   a_wr_taken: assert property (s_axi_awready |-> s_axi_wready
      && $past(s_axi_awvalid && s_axi_wvalid))
      else $error("Write taken without a request.");
   a_wr_answer: assert property (s_axi_awready |=> s_axi_bvalid)
      else $error("Write answer late.");
   a_rd_taken: assert property (s_axi_arready |-> $past(s_axi_arvalid))
      else $error("Read taken without a request.");
   a_rd_answer: assert property (s_axi_arready |=> s_axi_rvalid)
      else $error("Read answer late.");
   a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data dropped while stalled.");
   a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
      core_irq == 16'h0000 && chan_trigger == 64'h0)
      else $error("Outputs not cleared by reset.");

   c_irq: cover property (core_irq[15:4] != 12'h000);
   c_trig: cover property (chan_trigger != 64'h0);
   c_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind ier_router ier_router_chk chk_u (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_wvalid, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .reset_req, .nmi_req, .core_irq, .chan_trigger);

`default_nettype wire

// File: tb/ier_router_bench.sv
`timescale 1ns/10ps
`default_nettype none

// Self-checking bench for the event router.
module ier_router_bench;
   localparam logic [31:0] LO = ier_pkg::SEL_LOWER_ADDR;
   localparam logic [31:0] HI = ier_pkg::SEL_UPPER_ADDR;
   localparam logic [31:0] LL = ier_pkg::EVT_LATCH_LOW_ADDR;
   localparam logic [31:0] LH = ier_pkg::EVT_LATCH_HIGH_ADDR;
   localparam logic [1:0] OK = ier_pkg::RESP_OKAY;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, reset_req = 1'b0, nmi_req = 1'b0;
   logic [19:0] src = '0;
   logic [15:0] pin_x = '0, lf = 16'h003C;
   logic [63:0] xc = '0, xa = '0, exp_l;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] core_irq;
   logic [63:0] chan_trigger, chan_service;
   logic [4:0] sel [4:15];
   logic [33:0] rq [$];
   logic [1:0] bq [$];
   logic [11:0] iq [$];
   int n_errors = 0, n_tests = 0, n_cyc = 0, n_svc;

   // Clock of 25 ns.
   always #12.5 aclk = ~aclk;

   ier_router dut_u (.aclk, .aresetn, .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .reset_req, .nmi_req,
      .host_irq(src[0]), .timer0_irq(src[1]), .timer1_irq(src[2]),
      .timer2_irq(src[19]), .refresh_timer_irq(src[3]),
      .pin_event({pin_x[15:8], src[7:4], pin_x[3:1], src[16]}),
      .serial0_tx_event(src[12]), .serial0_rx_event(src[13]),
      .serial1_tx_event(src[14]), .serial1_rx_event(src[15]),
      .emulation_transfer_irq(src[9]), .emulation_rx_irq(src[10]),
      .emulation_tx_irq(src[11]), .xfer_complete(xc),
      .xfer_alt_complete(xa), .chan_service, .core_irq, .chan_trigger);

   ier_core_model far_u (.aclk, .aresetn, .core_irq, .chan_trigger,
      .chan_service, .n_svc);

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   // Builds a selector word from six shadow fields starting at line b.
   function automatic logic [31:0] pack(input int b);
      logic [31:0] w;
      w = '0;
      for (int i = 0; i < 6; i++)
         w = w | (32'(sel[b + i]) << (5 * i + int'(i > 2)));
      return w;
   endfunction

   task automatic bad(input string m);
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
   endtask

   task automatic cmp_rd(input logic [33:0] g);
      logic [33:0] e;
      e = rq.size() ? rq.pop_front() : 'x;
      n_tests++;
      if (e !== g) bad($sformatf("read %h want %h", g, e));
   endtask

   task automatic cmp_wr(input logic [1:0] g);
      logic [1:0] e;
      e = bq.size() ? bq.pop_front() : 'x;
      n_tests++;
      if (e !== g) bad($sformatf("write resp %h want %h", g, e));
   endtask

   task automatic cmp_irq(input logic [11:0] g);
      logic [11:0] e;
      e = iq.size() ? iq.pop_front() : 'x;
      n_tests++;
      if (e !== g) bad($sformatf("irq %h want %h", g, e));
   endtask

   task automatic cmp_cnt(input int e, input int g);
      n_tests++;
      if (e != g) bad($sformatf("services %0d want %0d", g, e));
   endtask

   // Bus write: address and data offered together, each released when taken.
   task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
      bq.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   // Bus read, with a random stall of the data channel.
   task automatic rd(input logic [31:0] a, input logic [33:0] e);
      rq.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= !lf[0];
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge aclk);
      if (!rready) begin
         @(posedge aclk);
         rready <= 1'b1;
         @(posedge aclk);
      end
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic settle();
      repeat (6) @(posedge aclk);
   endtask

   // Reads both event latches, then clears them.
   task automatic latch_chk(input logic [63:0] e);
      rd(LL, {OK, e[31:0]});
      rd(LH, {OK, e[63:32]});
      wr(LL, 32'hFFFFFFFF, OK);
      wr(LH, 32'hFFFFFFFF, OK);
   endtask

   task automatic report_and_stop();
      n_errors += iq.size() + rq.size() + bq.size();
      $display("errors %0d comparisons %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Takes each result off its queue as it appears; also the hang limit.
   always @(posedge aclk) begin
      n_cyc <= n_cyc + 1;
      if (aresetn && rvalid && rready) cmp_rd({rresp, rdata});
      if (aresetn && bvalid && bready) cmp_wr(bresp);
      if (aresetn && core_irq[15:4] !== 12'h000) cmp_irq(core_irq[15:4]);
      if (n_cyc > 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   // Main sequence.
   initial begin
      int line;
      int ch;
      logic [11:0] e;
      sel = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
              5'h03, 5'h0A, 5'h0B, 5'h00, 5'h01, 5'h02};
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(LO, {OK, pack(4)});
      rd(HI, {OK, pack(10)});
      rd(32'h019C0008, {ier_pkg::RESP_SLVERR, 32'h0});
      wr(32'h019C0008, 32'h12345678, ier_pkg::RESP_SLVERR);
      rd(LO, {OK, pack(4)});
      // Each legal code on a random line; reserved codes never written.
      for (int c = 0; c < 20; c++) begin
         if (c == 17 || c == 18) continue;
         lf = lfsr(lf);
         line = 4 + int'(lf % 12);
         sel[line] = 5'(c);
         ch = (line < 10) ? 4 : 10;
         wr(ch == 4 ? LO : HI, pack(ch) | 32'h80008000, OK);
         rd(ch == 4 ? LO : HI, {OK, pack(ch)});
         for (int i = 4; i < 16; i++) e[i - 4] = (sel[i] == 5'(c));
         iq.push_back(e);
         exp_l = '0;
         if (c == 8) begin
            ch = int'(lf[11:6]);
            xc[ch] <= 1'b1;
            @(posedge aclk);
            xc <= '0;
         end else begin
            src[c] <= 1'b1;
            ch = (c == 16) ? 8 : c;
            settle();
            src <= '0;
         end
         if (c < 9 || c > 11) exp_l[ch] = 1'b1;
         settle();
         latch_chk(exp_l);
      end
      // Pin events with no core line.
      for (int p = 1; p < 16; p++) begin
         if (p > 3 && p < 8) continue;
         exp_l = '0;
         exp_l[p < 8 ? p + 8 : p + 40] = 1'b1;
         pin_x[p] <= 1'b1;
         settle();
         pin_x <= '0;
         settle();
         latch_chk(exp_l);
      end
      // Alternate completion latches its own channel.
      ch = int'(lf[15:10]);
      exp_l = '0;
      exp_l[ch] = 1'b1;
      xa[ch] <= 1'b1;
      @(posedge aclk);
      xa <= '0;
      settle();
      latch_chk(exp_l);
      // Latched while not allowed, then serviced once allowed.
      pin_x[9] <= 1'b1;
      settle();
      rd(LH, {OK, 32'h00020000});
      wr(ier_pkg::EVT_ALLOW_HIGH_ADDR, 32'h00020000, OK);
      settle();
      pin_x <= '0;
      rd(LH, {OK, 32'h0});
      rd(ier_pkg::EVT_ALLOW_LOW_ADDR, {OK, 32'h0});
      cmp_cnt(1, n_svc);
      wr(ier_pkg::EVT_ALLOW_HIGH_ADDR, 32'h0, OK);
      // Fixed lines follow their requests.
      nmi_req <= 1'b1;
      reset_req <= 1'b1;
      settle();
      rd(ier_pkg::EVT_PEND_ADDR, {OK, 32'h00000003});
      nmi_req <= 1'b0;
      reset_req <= 1'b0;
      settle();
      rd(ier_pkg::EVT_PEND_ADDR, {OK, 32'h0});
      // Second reset restores the defaults.
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(LO, {OK, ier_pkg::SEL_LOWER_RST});
      rd(HI, {OK, ier_pkg::SEL_UPPER_RST});
      report_and_stop();
   end
endmodule

`default_nettype wire
